// [ffc_far_side.sv]
`timescale 1ns/100ps
module ffc_far_side
	import ffc_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              nrst_i,
	input  wire logic [3:0]        wr_div_i,
	input  wire logic [3:0]        rd_div_i,
	input  wire logic [15:0]       wr_total_i,
	input  wire logic              in_ready_i,
	output logic                   wr_tick_o,
	output logic                   rd_tick_o,
	output logic                   in_valid_o,
	output logic      [DATA_W-1:0] in_data_o,
	output logic      [15:0]       sent_o
);
	logic [3:0] wc_r;
	logic [3:0] rc_r;

	initial begin
		wc_r = 4'h0;
		rc_r = 4'h0;
		wr_tick_o = 1'b0;
		rd_tick_o = 1'b0;
		in_valid_o = 1'b0;
		in_data_o = '0;
	end

	// Words are counted only at the edge that takes them
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sent_o <= 16'h0000;
		end else if (in_valid_o && in_ready_i) begin
			sent_o <= sent_o + 16'h0001;
		end
	end

	// Ticks at unrelated rates so each edge kind can be told apart
	always @(negedge clk_i) begin
		wr_tick_o <= (wc_r == 4'h0);
		rd_tick_o <= (rc_r == 4'h0);
		wc_r <= (wc_r + 4'h1 >= wr_div_i) ? 4'h0 : wc_r + 4'h1;
		rc_r <= (rc_r + 4'h1 >= rd_div_i) ? 4'h0 : rc_r + 4'h1;
		in_valid_o <= (sent_o < wr_total_i);
		// Idle data is inverted so a stale word never looks valid
		in_data_o <= (sent_o < wr_total_i) ? DATA_W'(sent_o + 16'h0001)
			: ~DATA_W'(sent_o);
	end
endmodule // ffc_far_side

// [ffc_gsync.sv]
`timescale 1ns/100ps
module ffc_gsync
	import ffc_pkg::*;
#(
	parameter int unsigned W = 10
) (
	input  wire logic         clk_i,
	input  wire logic         nrst_i,
	input  wire logic         en_i,
	input  wire logic [W-1:0] gray_i,
	output logic      [W-1:0] bin_o
);
	logic [W-1:0] meta_r;
	logic [W-1:0] sync_r;

	// Gray code: only one bit moves per step, safe to sample
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			meta_r <= '0;
			sync_r <= '0;
		end else if (en_i) begin
			meta_r <= gray_i;
			sync_r <= meta_r;
		end
	end

	for (genvar i = 0; i < W; i++) begin : g_bin
		assign bin_o[i] = ^sync_r[W-1:i];
	end
endmodule // ffc_gsync

// [ffc_pkg.sv]
package ffc_pkg;

	localparam int unsigned DATA_W      = 18;
	localparam int unsigned DEPTH_DEF   = 256;
	localparam int unsigned DEPTH_256   = 256;
	localparam int unsigned DEPTH_512   = 512;
	localparam int unsigned OFS_W       = 12;
	localparam int unsigned CNT_W       = 16;
	localparam int unsigned STAGE_DEPTH = 8;

	// Offset defaults per depth variant
	localparam logic [OFS_W-1:0] OFS_D256 = 12'h01F;
	localparam logic [OFS_W-1:0] OFS_D512 = 12'h03F;
	localparam logic [OFS_W-1:0] OFS_DBIG = 12'h07F;

	// Strap settle: two sync cycles plus one, then latch
	localparam logic [1:0] CFG_WAIT = 2'h3;

	// Boundary flag buffering depths
	localparam logic [1:0] BUF_SINGLE = 2'h1;
	localparam logic [1:0] BUF_DOUBLE = 2'h2;
	localparam logic [1:0] BUF_TRIPLE = 2'h3;

	// Threshold adjustments
	localparam logic [CNT_W-1:0] FALL_THROUGH_MODE_XTRA   = 16'h0001;
	localparam logic [CNT_W-1:0] AE_ADD_FALL_THROUGH_MODE = 16'h0001;
	localparam logic [CNT_W-1:0] HF_ADD_STD  = 16'h0001;
	localparam logic [CNT_W-1:0] HF_ADD_FALL_THROUGH_MODE = 16'h0002;

	// Flag values after reset (active low pins)
	localparam logic AE_RST = 1'b0;
	localparam logic AF_RST = 1'b1;
	localparam logic HF_RST = 1'b1;
	localparam logic FF_RST = 1'b1;
	localparam logic EF_RST = 1'b0;

	typedef enum logic {FFC_STD = 1'b0, FFC_FALL_THROUGH_MODE = 1'b1} ffc_mode_t;
	typedef enum logic {FFC_ASYNC = 1'b0, FFC_SYNC = 1'b1} ffc_pf_t;
	typedef enum logic [1:0] {
		CF_SETTLE = 2'b00,
		CF_RUN    = 2'b01
	} ffc_phase_t;

	function automatic logic [OFS_W-1:0] ffc_def_offset(input int unsigned d);
		return (d == DEPTH_256) ? OFS_D256 :
			(d == DEPTH_512) ? OFS_D512 : OFS_DBIG;
	endfunction

endpackage

// [ffc_stage_fifo.sv]
`timescale 1ns/100ps
module ffc_stage_fifo
	import ffc_pkg::*;
#(
	parameter int unsigned W     = DATA_W,
	parameter int unsigned DEPTH = STAGE_DEPTH
) (
	input  wire logic         clk_i,
	input  wire logic         nrst_i,
	input  wire logic         in_valid_i,
	input  wire logic [W-1:0] in_data_i,
	output logic              in_ready_o,
	output logic              out_valid_o,
	output logic      [W-1:0] out_data_o,
	input  wire logic         out_ready_i
);
	// Depth must be a power of two; indices wrap naturally
	localparam int unsigned AW = $clog2(DEPTH);

	logic [W-1:0]  mem_r [DEPTH];
	logic [AW-1:0] wr_idx_r;
	logic [AW-1:0] rd_idx_r;
	logic [AW:0]   cnt_r;
	logic [AW:0]   cnt_nxt;
	logic          room_r;
	logic          push;
	logic          pop;

	assign push        = in_valid_i & room_r;
	assign pop         = out_valid_o & out_ready_i;
	assign out_valid_o = (cnt_r != '0);
	assign out_data_o  = mem_r[rd_idx_r];
	// Kept as a flop of its own so the ready pin has no gate after it
	assign in_ready_o  = room_r;
	assign cnt_nxt     = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_r[wr_idx_r] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wr_idx_r <= '0;
			rd_idx_r <= '0;
			cnt_r    <= '0;
			room_r   <= 1'b1;
		end else begin
			wr_idx_r <= wr_idx_r + {{(AW-1){1'b0}}, push};
			rd_idx_r <= rd_idx_r + {{(AW-1){1'b0}}, pop};
			cnt_r    <= cnt_nxt;
			room_r   <= (cnt_nxt != (AW+1)'(DEPTH));
		end
	end
endmodule // ffc_stage_fifo

// [ffc_top.sv]
`timescale 1ns/100ps
module ffc_top
	import ffc_pkg::*;
#(
	parameter int unsigned DEPTH = DEPTH_DEF
) (
	input  wire logic              clk_i,
	input  wire logic              nrst_i,
	input  wire logic              first_load_sel_i,
	input  wire logic              read_chain_in_i,
	input  wire logic              write_chain_in_i,
	input  wire logic              wr_tick_i,
	input  wire logic              in_valid_i,
	input  wire logic [DATA_W-1:0] in_data_i,
	output logic                   in_ready_o,
	input  wire logic              ofs_load_i,
	input  wire logic              ofs_full_sel_i,
	input  wire logic [OFS_W-1:0]  ofs_data_i,
	input  wire logic              rd_tick_i,
	input  wire logic              rd_req_i,
	output logic      [DATA_W-1:0] rd_data_o,
	output logic                   empty_flag_n_o,
	output logic                   full_flag_n_o,
	output logic                   half_full_flag_n_o,
	output logic                   almost_empty_flag_n_o,
	output logic                   almost_full_flag_n_o,
	output logic                   fall_through_mode_o,
	output logic                   pf_sync_mode_o,
	output logic                   cfg_done_o
);
	localparam int unsigned AW = $clog2(DEPTH);
	// Two spare bits: count up to D+1 without pointer aliasing
	localparam int unsigned PW = AW + 2;
	localparam logic [CNT_W-1:0] D16 = CNT_W'(DEPTH);

	logic [DATA_W-1:0] mem_r [DEPTH];

	logic [2:0]        strap_meta_r;
	logic [2:0]        strap_sync_r;
	ffc_phase_t        phase_r;
	logic [1:0]        settle_r;
	ffc_mode_t         mode_r;
	ffc_pf_t           pf_r;
	logic [1:0]        emp_buf_r;
	logic [1:0]        full_buf_r;
	logic              run;
	logic              fall_through_mode;
	logic              latch_now;

	logic [OFS_W-1:0]  ofs_empty_r;
	logic [OFS_W-1:0]  ofs_full_r;

	logic              stg_valid;
	logic [DATA_W-1:0] stg_data;
	logic [PW-1:0]     wptr_r;
	logic [PW-1:0]     wptr_nxt;
	logic [PW-1:0]     wgray_r;
	logic [PW-1:0]     cptr_ws;
	logic [PW-1:0]     cptr_r;
	logic [PW-1:0]     cptr_nxt;
	logic [PW-1:0]     cgray_r;
	logic [PW-1:0]     fptr_r;
	logic [PW-1:0]     wptr_rs;
	logic              ov_r;
	logic              wr_go;
	logic              consume;
	logic              fetch;
	logic              mem_has;

	logic [CNT_W-1:0]  wcnt;
	logic [CNT_W-1:0]  wcnt_nxt;
	logic [CNT_W-1:0]  rcnt;
	logic [CNT_W-1:0]  rcnt_nxt;
	logic [CNT_W-1:0]  cap;
	logic [CNT_W-1:0]  ae_thr;
	logic [CNT_W-1:0]  hf_thr;
	logic [CNT_W-1:0]  af_thr;

	logic [2:0]        emp_pipe_r;
	logic [2:0]        full_pipe_r;
	logic              emp_sel;
	logic              full_sel;

	// Straps are pins: two flops; they run in reset so the empty flag sees the mode
	always_ff @(posedge clk_i) begin
		strap_meta_r <= {first_load_sel_i, read_chain_in_i,
			write_chain_in_i};
		strap_sync_r <= strap_meta_r;
	end

	// Configuration phase after reset release
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			phase_r  <= CF_SETTLE;
			settle_r <= 2'h0;
		end else begin
			unique case (phase_r)
				CF_SETTLE: begin
					if (settle_r == CFG_WAIT) begin
						phase_r <= CF_RUN;
					end else begin
						settle_r <= settle_r + 2'h1;
					end
				end
				CF_RUN: phase_r <= CF_RUN;
				default: phase_r <= CF_SETTLE;
			endcase
		end
	end

	assign latch_now = (phase_r == CF_SETTLE) && (settle_r == CFG_WAIT);
	assign run       = cfg_done_o;
	assign fall_through_mode      = (mode_r == FFC_FALL_THROUGH_MODE);

	// Latched once; strap changes later have no effect
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			mode_r              <= FFC_STD;
			pf_r                <= FFC_ASYNC;
			emp_buf_r           <= BUF_SINGLE;
			full_buf_r          <= BUF_SINGLE;
			fall_through_mode_o <= 1'b0;
			pf_sync_mode_o      <= 1'b0;
			cfg_done_o          <= 1'b0;
		end else if (latch_now) begin
			cfg_done_o <= 1'b1;
			unique case (strap_sync_r[1:0])
				2'b00: begin
					mode_r              <= FFC_STD;
					pf_r                <= ffc_pf_t'(strap_sync_r[2]);
					emp_buf_r           <= BUF_SINGLE;
					full_buf_r          <= BUF_SINGLE;
					fall_through_mode_o <= 1'b0;
					pf_sync_mode_o      <= strap_sync_r[2];
				end
				2'b01: begin
					mode_r              <= FFC_FALL_THROUGH_MODE;
					pf_r                <= ffc_pf_t'(strap_sync_r[2]);
					emp_buf_r           <= BUF_TRIPLE;
					full_buf_r          <= BUF_DOUBLE;
					fall_through_mode_o <= 1'b1;
					pf_sync_mode_o      <= strap_sync_r[2];
				end
				2'b10: begin
					mode_r              <= FFC_STD;
					pf_r                <= ffc_pf_t'(strap_sync_r[2]);
					emp_buf_r           <= BUF_DOUBLE;
					full_buf_r          <= BUF_DOUBLE;
					fall_through_mode_o <= 1'b0;
					pf_sync_mode_o      <= strap_sync_r[2];
				end
				2'b11: begin
					mode_r              <= FFC_STD;
					pf_r                <= FFC_ASYNC;
					emp_buf_r           <= BUF_SINGLE;
					full_buf_r          <= BUF_SINGLE;
					fall_through_mode_o <= 1'b0;
					pf_sync_mode_o      <= 1'b0;
				end
			endcase
		end
	end

	// Offset registers, loaded on write ticks
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ofs_empty_r <= ffc_def_offset(DEPTH);
			ofs_full_r  <= ffc_def_offset(DEPTH);
		end else if (wr_tick_i && ofs_load_i) begin
			if (ofs_full_sel_i) begin
				ofs_full_r <= ofs_data_i;
			end else begin
				ofs_empty_r <= ofs_data_i;
			end
		end
	end

	ffc_stage_fifo #(
		.W     (DATA_W),
		.DEPTH (STAGE_DEPTH)
	) u_stage (
		.clk_i       (clk_i),
		.nrst_i      (nrst_i),
		.in_valid_i  (in_valid_i),
		.in_data_i   (in_data_i),
		.in_ready_o  (in_ready_o),
		.out_valid_o (stg_valid),
		.out_data_o  (stg_data),
		.out_ready_i (wr_go)
	);

	// Pointer crossings, each sampled on the far side's tick
	ffc_gsync #(.W(PW)) u_wsync (
		.clk_i  (clk_i),
		.nrst_i (nrst_i),
		.en_i   (rd_tick_i),
		.gray_i (wgray_r),
		.bin_o  (wptr_rs)
	);

	ffc_gsync #(.W(PW)) u_csync (
		.clk_i  (clk_i),
		.nrst_i (nrst_i),
		.en_i   (wr_tick_i),
		.gray_i (cgray_r),
		.bin_o  (cptr_ws)
	);

	// Thresholds
	always_comb begin
		cap    = fall_through_mode ? D16 + FALL_THROUGH_MODE_XTRA : D16;
		ae_thr = CNT_W'(ofs_empty_r) + (fall_through_mode ? AE_ADD_FALL_THROUGH_MODE : '0);
		hf_thr = (D16 >> 1) + (fall_through_mode ? HF_ADD_FALL_THROUGH_MODE : HF_ADD_STD);
		af_thr = cap - CNT_W'(ofs_full_r);
	end

	// Write side
	assign wcnt     = CNT_W'(PW'(wptr_r - cptr_ws));
	assign wr_go    = wr_tick_i & run & stg_valid & ~ofs_load_i &
		(wcnt != cap);
	assign wptr_nxt = wptr_r + PW'(wr_go);
	assign wcnt_nxt = CNT_W'(PW'(wptr_nxt - cptr_ws));

	always_ff @(posedge clk_i) begin
		if (wr_go) begin
			mem_r[wptr_r[AW-1:0]] <= stg_data;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wptr_r  <= '0;
			wgray_r <= '0;
		end else if (wr_go) begin
			wptr_r  <= wptr_nxt;
			wgray_r <= wptr_nxt ^ (wptr_nxt >> 1);
		end
	end

	// Read side; fall-through keeps one word staged in rd_data_o
	assign rcnt     = CNT_W'(PW'(wptr_rs - cptr_r));
	assign mem_has  = (wptr_rs != fptr_r);
	assign consume  = rd_tick_i & run & rd_req_i &
		(fall_through_mode ? ov_r : mem_has);
	assign fetch    = fall_through_mode ? (rd_tick_i & run & mem_has & (~ov_r | consume))
		: consume;
	assign cptr_nxt = cptr_r + PW'(consume);
	assign rcnt_nxt = CNT_W'(PW'(wptr_rs - cptr_nxt));

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cptr_r    <= '0;
			cgray_r   <= '0;
			fptr_r    <= '0;
			ov_r      <= 1'b0;
			rd_data_o <= '0;
		end else begin
			if (consume) begin
				cptr_r  <= cptr_nxt;
				cgray_r <= cptr_nxt ^ (cptr_nxt >> 1);
			end
			if (fetch) begin
				fptr_r    <= fptr_r + PW'(1);
				rd_data_o <= mem_r[fptr_r[AW-1:0]];
			end
			if (fall_through_mode && fetch) begin
				ov_r <= 1'b1;
			end else if (consume) begin
				ov_r <= 1'b0;
			end
		end
	end

	// Boundary flags: pipeline holds "at boundary", stage picked by strap
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			emp_pipe_r <= 3'h7;
		end else if (rd_tick_i && run) begin
			emp_pipe_r <= {emp_pipe_r[1:0], rcnt_nxt == '0};
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			full_pipe_r <= 3'h0;
		end else if (wr_tick_i && run) begin
			full_pipe_r <= {full_pipe_r[1:0], wcnt_nxt == cap};
		end
	end

	assign emp_sel  = emp_pipe_r[emp_buf_r - 2'h1];
	assign full_sel = full_pipe_r[full_buf_r - 2'h1];

	// Standard pins are low at the boundary; ready pins invert that
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			full_flag_n_o <= FF_RST;
		end else begin
			full_flag_n_o <= fall_through_mode ? full_sel : ~full_sel;
		end
	end

	// No async reset: its level in reset depends on the strapped mode
	always_ff @(posedge clk_i) begin
		if (!run) begin
			empty_flag_n_o <= (strap_sync_r[1:0] == 2'b01) ? ~EF_RST
				: EF_RST;
		end else begin
			empty_flag_n_o <= fall_through_mode ? emp_sel : ~emp_sel;
		end
	end

	// Partial flags are never buffered
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			almost_empty_flag_n_o <= AE_RST;
		end else if (run) begin
			unique case (pf_r)
				FFC_SYNC: begin
					if (rd_tick_i) begin
						almost_empty_flag_n_o <= (rcnt_nxt > ae_thr);
					end
				end
				FFC_ASYNC: begin
					if (rd_tick_i && rcnt_nxt <= ae_thr) begin
						almost_empty_flag_n_o <= 1'b0;
					end else if (wr_tick_i && wcnt_nxt > ae_thr) begin
						almost_empty_flag_n_o <= 1'b1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			almost_full_flag_n_o <= AF_RST;
		end else if (run) begin
			unique case (pf_r)
				FFC_SYNC: begin
					if (wr_tick_i) begin
						almost_full_flag_n_o <= (wcnt_nxt < af_thr);
					end
				end
				FFC_ASYNC: begin
					if (wr_tick_i && wcnt_nxt >= af_thr) begin
						almost_full_flag_n_o <= 1'b0;
					end else if (rd_tick_i && rcnt_nxt < af_thr) begin
						almost_full_flag_n_o <= 1'b1;
					end
				end
			endcase
		end
	end

	// Updated by whichever side moved; write side wins a tie
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			half_full_flag_n_o <= HF_RST;
		end else if (run && wr_tick_i) begin
			half_full_flag_n_o <= (wcnt_nxt < hf_thr);
		end else if (run && rd_tick_i) begin
			half_full_flag_n_o <= (rcnt_nxt < hf_thr);
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	sequence s_last_read;
		run && !fall_through_mode && emp_buf_r == BUF_SINGLE && rd_tick_i &&
			rcnt_nxt == '0;
	endsequence

	sequence s_async_step;
		run && pf_r == FFC_ASYNC ##1 1'b1;
	endsequence

	a_cfg_frozen: assert property (cfg_done_o && $past(cfg_done_o) |->
		$stable(mode_r) && $stable(pf_r) && $stable(emp_buf_r))
		else $error("configuration changed after latch");

	a_cfg_fall_through_mode_bufs: assert property (latch_now &&
		strap_sync_r[1:0] == 2'b01 |=> fall_through_mode &&
		emp_buf_r == BUF_TRIPLE && full_buf_r == BUF_DOUBLE)
		else $error("fall-through buffering wrong");

	a_cfg_chain_both: assert property (latch_now &&
		strap_sync_r[1:0] == 2'b11 |=> pf_r == FFC_ASYNC && !fall_through_mode &&
		emp_buf_r == BUF_SINGLE && !pf_sync_mode_o)
		else $error("chain 11 not async single");

	a_ae_sync_rd: assert property (run && pf_r == FFC_SYNC &&
		!rd_tick_i |=> $stable(almost_empty_flag_n_o))
		else $error("sync almost-empty moved without read tick");

	a_af_sync_wr: assert property (run && pf_r == FFC_SYNC &&
		!wr_tick_i |=> $stable(almost_full_flag_n_o))
		else $error("sync almost-full moved without write tick");

	a_ae_async_edge: assert property (s_async_step |->
		(!$fell(almost_empty_flag_n_o) || $past(rd_tick_i)) &&
		(!$rose(almost_empty_flag_n_o) || $past(wr_tick_i)))
		else $error("async almost-empty on wrong tick");

	a_af_async_edge: assert property (s_async_step |->
		(!$fell(almost_full_flag_n_o) || $past(wr_tick_i)) &&
		(!$rose(almost_full_flag_n_o) || $past(rd_tick_i)))
		else $error("async almost-full on wrong tick");

	a_full_no_write: assert property (wr_tick_i && wcnt == cap
		|=> $stable(wptr_r))
		else $error("write accepted while full");

	a_empty_no_read: assert property (rd_tick_i && rcnt == '0
		|=> $stable(cptr_r))
		else $error("read accepted while empty");

	a_empty_single_lat: assert property (s_last_read |->
		##2 !empty_flag_n_o)
		else $error("single-buffered empty flag late");

	a_hf_std_level: assert property (run && !fall_through_mode && wr_tick_i &&
		wcnt_nxt > (D16 >> 1) |=> !half_full_flag_n_o)
		else $error("half-full not low above half");
endmodule // ffc_top

// [tb_top.sv]
`timescale 1ns/100ps
module tb_top
	import ffc_pkg::*;
;
	localparam int D = 256;
	localparam int N = 31;

	logic              clk;
	logic              nrst;
	logic              first_load_sel;
	logic              read_chain_in;
	logic              write_chain_in;
	logic              wr_tick;
	logic              rd_tick;
	logic              in_valid;
	logic              in_ready;
	logic              rd_req;
	logic [DATA_W-1:0] in_data;
	logic [DATA_W-1:0] rd_data;
	logic [OFS_W-1:0]  ofs_data;
	logic              ef_n;
	logic              ff_n;
	logic              hf_n;
	logic              ae_n;
	logic              af_n;
	logic              ftm;
	logic              pfs;
	logic              cfg_done;
	logic [3:0]        wr_div;
	logic [3:0]        rd_div;
	logic [15:0]       wr_total;
	logic [15:0]       sent;
	logic              ae_q;
	logic              af_q;
	logic              wt_q;
	logic              rt_q;
	bit                mon_on;
	int                bad_count;
	int                num_checks;
	int                cyc;
	int                l1;
	int                l2;
	int                pts_std [9] = '{1, 31, 32, 128, 129, 224, 225,
		255, 256};
	int                pts_ft [9] = '{1, 32, 33, 129, 130, 225, 226,
		256, 257};

	ffc_top #(.DEPTH(D)) DUT (
		.clk_i(clk), .nrst_i(nrst), .first_load_sel_i(first_load_sel),
		.read_chain_in_i(read_chain_in), .write_chain_in_i(write_chain_in),
		.wr_tick_i(wr_tick), .in_valid_i(in_valid), .in_data_i(in_data),
		.in_ready_o(in_ready), .ofs_load_i(1'b0), .ofs_full_sel_i(1'b0),
		.ofs_data_i(ofs_data), .rd_tick_i(rd_tick), .rd_req_i(rd_req),
		.rd_data_o(rd_data), .empty_flag_n_o(ef_n), .full_flag_n_o(ff_n),
		.half_full_flag_n_o(hf_n), .almost_empty_flag_n_o(ae_n),
		.almost_full_flag_n_o(af_n), .fall_through_mode_o(ftm),
		.pf_sync_mode_o(pfs), .cfg_done_o(cfg_done));

	ffc_far_side far (
		.clk_i(clk), .nrst_i(nrst), .wr_div_i(wr_div), .rd_div_i(rd_div),
		.wr_total_i(wr_total), .in_ready_i(in_ready), .wr_tick_o(wr_tick),
		.rd_tick_o(rd_tick), .in_valid_o(in_valid), .in_data_o(in_data),
		.sent_o(sent));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic close_out;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Straps are level pins, so they are set before reset opens
	task automatic do_reset(input logic [2:0] code);
		int k;
		nrst = 1'b0;
		// Far side clears sent_o on this edge too; wr_total is read at each falling clock
		wr_total <= 16'h0000;
		{first_load_sel, read_chain_in, write_chain_in} = code;
		repeat (8) @(negedge clk);
		check("rst_empty", ef_n, code[1:0] == 2'b01);
		check("rst_full", ff_n, 1);
		check("rst_half", hf_n, 1);
		check("rst_aempty", ae_n, 0);
		check("rst_afull", af_n, 1);
		check("rst_data", rd_data, 0);
		nrst = 1'b1;
		k = 0;
		while (cfg_done !== 1'b1 && k < 20) begin
			@(negedge clk);
			k++;
		end
		check("cfg_done", cfg_done, 1);
	endtask

	task automatic settle;
		repeat (60) @(negedge clk);
	endtask

	task automatic fill_to(input int c);
		int k;
		wr_total <= 16'(c);
		k = 0;
		while (sent < 16'(c) && k < 4000) begin
			@(negedge clk);
			k++;
		end
		settle();
	endtask

	task automatic chk_flags(input int c, input bit ft);
		check("empty", ef_n, ft ? (c == 0) : (c != 0));
		check("full", ff_n, ft ? (c == D + 1) : (c != D));
		check("half", hf_n, ft ? (c < D / 2 + 2) : (c <= D / 2));
		check("aempty", ae_n, ft ? (c > N + 1) : (c > N));
		check("afull", af_n, ft ? (c < D + 1 - N) : (c < D - N));
	endtask

	// Request held until a read tick has sampled it
	task automatic rd_one(input int exp);
		int k;
		rd_req = 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (rd_tick !== 1'b1 && k < 20);
		@(negedge clk);
		rd_req = 1'b0;
		repeat (2) @(negedge clk);
		if (exp >= 0)
			check("rd_data", rd_data, exp);
	endtask

	task automatic lat(input logic [2:0] code, output int l);
		do_reset(code);
		wr_total <= 16'h0001;
		l = 0;
		while (ef_n !== 1'b1 && l < 100) begin
			@(negedge clk);
			l++;
		end
	endtask

	always @(posedge clk) begin
		wt_q <= wr_tick;
		rt_q <= rd_tick;
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			close_out();
		end
	end

	// Flags are flops, so a change names the tick of the edge before
	always @(negedge clk) begin
		if (mon_on && cfg_done === 1'b1) begin
			if (ae_n !== ae_q)
				check("ae_tick", (pfs || !ae_n) ? rt_q : wt_q, 1);
			if (af_n !== af_q)
				check("af_tick", (pfs || !af_n) ? wt_q : rt_q, 1);
		end
		ae_q <= ae_n;
		af_q <= af_n;
	end

	initial begin
		nrst = 1'b0;
		{first_load_sel, read_chain_in, write_chain_in} = 3'h0;
		rd_req = 1'b0;
		ofs_data = 12'h000;
		wr_div = 4'h1;
		rd_div = 4'h1;
		wr_total = 16'h0000;
		mon_on = 1'b0;
		bad_count = 0;
		num_checks = 0;
		cyc = 0;
		for (int c = 0; c < 8; c++) begin
			do_reset(3'(c));
			check("fall_through_mode", ftm, c[1:0] == 2'b01);
			check("sync", pfs, c[2] && c[1:0] != 2'b11);
			{first_load_sel, read_chain_in, write_chain_in} = ~3'(c);
			repeat (10) @(negedge clk);
			check("fall_through_mode_hold", ftm, c[1:0] == 2'b01);
			check("sync_hold", pfs, c[2] && c[1:0] != 2'b11);
		end
		lat(3'b000, l1);
		lat(3'b010, l2);
		check("lat_step", l2 - l1, 1);
		// Standard, synchronous partial flags, ticks at differing rates
		wr_div <= 4'h2;
		rd_div <= 4'h3;
		do_reset(3'b100);
		mon_on = 1'b1;
		settle();
		chk_flags(0, 0);
		for (int i = 0; i < 9; i++) begin
			fill_to(pts_std[i]);
			chk_flags(pts_std[i], 0);
		end
		// Eight more words wait in the stage while the memory is full
		fill_to(264);
		chk_flags(256, 0);
		check("in_ready", in_ready, 0);
		for (int i = 0; i < 264; i++) begin
			rd_one(i + 1);
			if (263 - i == D - N - 1 || 263 - i == D / 2 ||
				263 - i == N + 1 || 263 - i == N) begin
				settle();
				chk_flags(263 - i, 0);
			end
		end
		settle();
		chk_flags(0, 0);
		rd_one(264);
		// Fall-through, asynchronous partial flags
		wr_div <= 4'h3;
		rd_div <= 4'h2;
		do_reset(3'b001);
		settle();
		chk_flags(0, 1);
		for (int i = 0; i < 9; i++) begin
			fill_to(pts_ft[i]);
			chk_flags(pts_ft[i], 1);
			if (i == 0)
				check("ft_word", rd_data, 1);
		end
		for (int i = 0; i < 226; i++)
			rd_one(-1);
		settle();
		chk_flags(31, 1);
		check("ft_next", rd_data, 227);
		close_out();
	end
endmodule // tb_top
